/* File: pkg/ssw_pkg.sv */
package ssw_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ         = 100_000_000;
  // Reset timeout, typical figure in ms
  localparam int unsigned RST_TIMEOUT_MS = 200;
  localparam int unsigned RST_TIMEOUT_CYC = CLK_HZ / 1000 * RST_TIMEOUT_MS;
  // Watchdog period in ms (1.6 s)
  localparam int unsigned WDOG_MS        = 1600;
  localparam int unsigned WDOG_CYC       = CLK_HZ / 1000 * WDOG_MS;
  // Internal write cycle, ms
  localparam int unsigned WCYC_MS        = 5;
  localparam int unsigned WCYC_CYC       = CLK_HZ / 1000 * WCYC_MS;
  // Manual reset debounce, us
  localparam int unsigned DEB_US         = 10;
  localparam int unsigned DEB_CYC        = CLK_HZ / 1_000_000 * DEB_US;
  // Memory shape
  localparam int unsigned MEM_BITS       = 2048;
  localparam int unsigned MEM_BYTES      = MEM_BITS / 8;
  localparam int unsigned PAGE_BYTES     = 16;
  localparam int unsigned ADDR_W         = 8;
  // Counter width covering the longest count
  localparam int unsigned CNT_W          = 32;
  // Variants
  localparam int unsigned VAR_SDA_WP     = 0;
  localparam int unsigned VAR_REDUCED    = 1;
  localparam int unsigned VAR_KICK       = 2;
  // Reset values
  localparam logic        RST_ACTIVE_RST = 1'b1;
  // Sequencer states
  typedef enum logic [2:0] {
    SSW_HOLD = 3'b001,
    SSW_TOUT = 3'b010,
    SSW_RUN  = 3'b100
  } ssw_state_t;
endpackage

/* File: rtl/ssw_supervisor.sv */
`timescale 1ns/1ns
// Operation
// - Low supply asserts both reset outputs
// - Hold reset 200 ms after supply recovers
// - 1.6 s watchdog, source per variant
// - Any kick edge restarts the watchdog
// - External low on reset pin starts reset
// - Manual reset debounced, low starts reset
// - Reset held while manual low, plus timeout
// - Unconnected manual input reads high
// - Write protect high blocks all writes
// - Writes blocked while supply below threshold
// - Gating serves 2k-bit, 16-byte page memory
// - Reduced variant: low reset only, no protect
// - Reset outputs are open drain
// - Interface disabled during 5 ms write cycle
module ssw_supervisor #(
  parameter int unsigned VARIANT         = ssw_pkg::VAR_SDA_WP,
  parameter int unsigned RST_TIMEOUT_CYC = ssw_pkg::RST_TIMEOUT_CYC,
  parameter int unsigned WDOG_CYC        = ssw_pkg::WDOG_CYC,
  parameter int unsigned WCYC_CYC        = ssw_pkg::WCYC_CYC
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     rst_i,
  // Supply comparator
  input  wire logic                     supply_low_i,
  // Manual reset and write protect, pull state given
  input  wire logic                     manual_reset_in_i,
  input  wire logic                     manual_reset_conn_i,
  input  wire logic                     write_protect_in_i,
  input  wire logic                     write_protect_conn_i,
  // Watchdog activity sources
  input  wire logic                     sda_i,
  input  wire logic                     watchdog_kick_in_i,
  // Open-drain reset pins
  input  wire logic                     reset_out_n_i,
  output logic                          reset_out_n_o,
  output logic                          reset_out_n_oe_o,
  output logic                          reset_out_p_o,
  output logic                          reset_out_p_oe_o,
  // Memory write request from the serial engine
  input  wire logic                     wr_req_i,
  input  wire logic [ssw_pkg::ADDR_W-1:0] wr_addr_i,
  input  wire logic                     wr_stop_i,
  output logic                          wr_allow_o,
  output logic                          wr_busy_o,
  output logic                          serial_enable_o
);

  // Sequencer state and counters
  ssw_pkg::ssw_state_t       state_reg;
  ssw_pkg::ssw_state_t       state_next;
  logic [ssw_pkg::CNT_W-1:0] tout_cnt_reg;    // Reset timeout counter
  logic [ssw_pkg::CNT_W-1:0] wdog_cnt_reg;    // Watchdog counter
  logic [ssw_pkg::CNT_W-1:0] deb_cnt_reg;     // Debounce counter
  logic [ssw_pkg::CNT_W-1:0] wcyc_cnt_reg;    // Write cycle counter
  logic                      manual_level;    // Manual level after pull-up
  logic                      manual_deb_reg;  // Debounced manual level
  logic                      kick_src;        // Selected watchdog source
  logic                      kick_prev_reg;   // Last source sample
  logic                      kick_edge;       // Any edge on source
  logic                      wdog_fire;       // Watchdog expiry
  logic                      ext_low;         // Pin pulled low by others
  logic                      cause;           // Any active reset cause
  logic                      rst_asserted;    // Outputs active
  logic                      wp_level;        // Protect level after pull-down
  logic                      wr_busy_reg;     // Internal write cycle running

  // Unconnected manual input reads as high
  assign manual_level = manual_reset_conn_i ? manual_reset_in_i : 1'b1;

  // Debounce: level must stay steady for DEB_CYC before it is taken
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      manual_deb_reg <= 1'b1;
      deb_cnt_reg    <= '0;
    end else if (manual_level == manual_deb_reg) begin
      deb_cnt_reg <= '0;
    end else if (deb_cnt_reg >= ssw_pkg::CNT_W'(ssw_pkg::DEB_CYC - 1)) begin
      manual_deb_reg <= manual_level;
      deb_cnt_reg <= '0;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  // Watchdog source: serial data line or dedicated kick pin
  assign kick_src  = (VARIANT == ssw_pkg::VAR_KICK) ? watchdog_kick_in_i : sda_i;
  assign kick_edge = kick_src ^ kick_prev_reg;

  // Pin observed low while we are not driving it means an outside pull
  // Limitation: a pull still held at release retriggers after one free cycle
  assign ext_low   = !reset_out_n_i && !rst_asserted;
  assign wdog_fire = (state_reg == ssw_pkg::SSW_RUN) &&
                     (wdog_cnt_reg >= ssw_pkg::CNT_W'(WDOG_CYC - 1));
  assign cause     = supply_low_i || !manual_deb_reg || ext_low || wdog_fire;
  assign rst_asserted = (state_reg != ssw_pkg::SSW_RUN);

  // Next state: any cause returns to hold; timeout restarts on each cause
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // Our own drive reads low on the pin, so it is not a cause while held
      ssw_pkg::SSW_HOLD: if (!(supply_low_i || !manual_deb_reg)) state_next = ssw_pkg::SSW_TOUT;
      ssw_pkg::SSW_TOUT: begin
        if (supply_low_i || !manual_deb_reg)
          state_next = ssw_pkg::SSW_HOLD;
        else if (tout_cnt_reg >= ssw_pkg::CNT_W'(RST_TIMEOUT_CYC - 1))
          state_next = ssw_pkg::SSW_RUN;
      end
      ssw_pkg::SSW_RUN: if (cause) state_next = ssw_pkg::SSW_HOLD;
      default: state_next = ssw_pkg::SSW_HOLD;
    endcase
  end

  // State register; powers up holding reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) state_reg <= ssw_pkg::SSW_HOLD;
    else       state_reg <= state_next;
  end

  // Timeout counter runs only in the timeout state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i)                              tout_cnt_reg <= '0;
    else if (state_reg != ssw_pkg::SSW_TOUT) tout_cnt_reg <= '0;
    else                                    tout_cnt_reg <= tout_cnt_reg + 1'b1;
  end

  // Watchdog counter; held at zero whenever reset is out
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_cnt_reg  <= '0;
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_src;
      if (rst_asserted || kick_edge) wdog_cnt_reg <= '0;
      else                           wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
    end
  end

  // Open drain: drive only the asserted level, release otherwise
  assign reset_out_n_o    = 1'b0;
  assign reset_out_n_oe_o = rst_asserted;
  assign reset_out_p_o    = 1'b1;
  assign reset_out_p_oe_o = rst_asserted && (VARIANT != ssw_pkg::VAR_REDUCED);

  // Protect pin; absent in reduced build, pull-down when open
  assign wp_level = (VARIANT == ssw_pkg::VAR_REDUCED) ? 1'b0 :
                    (write_protect_conn_i ? write_protect_in_i : 1'b0);

  // Write gate over the whole 2k-bit array, addresses past its end refused
  assign wr_allow_o = wr_req_i && !wp_level && !supply_low_i && !wr_busy_reg &&
                      (32'(wr_addr_i) < ssw_pkg::MEM_BYTES);

  // Write cycle: started on a granted write's stop, lasts up to 5 ms
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_busy_reg  <= 1'b0;
      wcyc_cnt_reg <= '0;
    end else if (wr_busy_reg) begin
      if (wcyc_cnt_reg >= ssw_pkg::CNT_W'(WCYC_CYC - 1)) begin
        wr_busy_reg  <= 1'b0;
        wcyc_cnt_reg <= '0;
      end else begin
        wcyc_cnt_reg <= wcyc_cnt_reg + 1'b1;
      end
    end else if (wr_stop_i && wr_allow_o) begin
      wr_busy_reg <= 1'b1;
    end
  end

  assign wr_busy_o       = wr_busy_reg;
  assign serial_enable_o = !wr_busy_reg;

  // Timeout must expire before release
  sequence tout_full_s;
    (state_reg == ssw_pkg::SSW_TOUT) && (tout_cnt_reg == 0);
  endsequence
  low_supply_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    supply_low_i |=> reset_out_n_oe_o)
    else $error("reset not driven on low supply");
  timeout_min_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_asserted) |-> $past(tout_cnt_reg) == ssw_pkg::CNT_W'(RST_TIMEOUT_CYC - 1))
    else $error("reset released before timeout");
  wdog_fire_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wdog_fire |=> reset_out_n_oe_o)
    else $error("watchdog expiry missed");
  kick_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    kick_edge |=> wdog_cnt_reg == 0)
    else $error("kick did not restart watchdog");
  ext_pull_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ext_low |=> rst_asserted [*2])
    else $error("external reset not held");
  manual_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !manual_deb_reg |=> rst_asserted)
    else $error("manual reset not held");
  wp_block_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wp_level |-> !wr_allow_o)
    else $error("write allowed while protected");
  supply_block_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    supply_low_i |-> !wr_allow_o)
    else $error("write allowed on low supply");
  open_drain_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !reset_out_n_o && reset_out_p_o)
    else $error("released level driven");
  wcyc_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(wr_busy_reg) |-> !serial_enable_o [*8])
    else $error("interface active in write cycle");
  wdog_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    tout_full_s |-> wdog_cnt_reg == 0)
    else $error("watchdog counted during reset");
  // Debounced level moves only after a full steady span
  manual_settle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(manual_deb_reg) |-> $past(deb_cnt_reg) == ssw_pkg::CNT_W'(ssw_pkg::DEB_CYC - 1))
    else $error("manual level taken before debounce");
  // Active-high output never asserts on its own
  reset_pair_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    reset_out_p_oe_o |-> reset_out_n_oe_o)
    else $error("high reset driven without low reset");

endmodule

/* File: tb/ssw_host_model.sv */
`timescale 1ns/1ns
// Host controller: kicks the watchdog, may pull the reset wire
module ssw_host_model #(
  parameter int KICK_PER = 100  // Cycles between kick edges
) (
  // Clock and controls
  input  wire logic mclk_i,
  input  wire logic kick_en_i,
  input  wire logic pull_low_i,
  // Device side
  input  wire logic oe_i,
  output logic      kick_o,
  output logic      pin_o
);
  int   cnt    = 0;     // Cycles since last slot
  logic kick_q = 1'b0;  // Kick level, single driver
  assign kick_o = kick_q;
  // Toggle well inside the watchdog period
  always @(posedge mclk_i) begin
    cnt <= (cnt == KICK_PER - 1) ? 0 : cnt + 1;
    if (kick_en_i && cnt == KICK_PER - 1) begin
      kick_q <= ~kick_q;
    end
  end
  // Wire with pull-up, low if either party sinks it
  assign pin_o = (oe_i | pull_low_i) ? 1'b0 : 1'b1;
endmodule

/* File: tb/supply_supervisor_watchdog_reset_tb_top.sv */
`timescale 1ns/1ns
module supply_supervisor_watchdog_reset_tb_top;
  logic       mclk_i, rst_i = 1'b1, sup = 1'b1, man = 1'b1, man_conn = 1'b1;
  logic       wp = 1'b0, wp_conn = 1'b0, kick_en = 1'b1, pull = 1'b0;
  logic       req = 1'b1, stop = 1'b0, sda = 1'b1;
  logic [7:0] addr = 8'hFF;  // Top byte of the array
  wire        kick, pin, oe_n, oe_p, n_o, p_o, allow, busy, sen;
  int         err_total = 0, compares = 0;
  // Counts shortened so the run stays brief
  ssw_supervisor #(.VARIANT(2), .RST_TIMEOUT_CYC(50), .WDOG_CYC(200), .WCYC_CYC(20)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .supply_low_i(sup), .manual_reset_in_i(man),
    .manual_reset_conn_i(man_conn), .write_protect_in_i(wp), .write_protect_conn_i(wp_conn),
    .sda_i(sda), .watchdog_kick_in_i(kick), .reset_out_n_i(pin), .reset_out_n_o(n_o),
    .reset_out_n_oe_o(oe_n), .reset_out_p_o(p_o), .reset_out_p_oe_o(oe_p), .wr_req_i(req),
    .wr_addr_i(addr), .wr_stop_i(stop), .wr_allow_o(allow), .wr_busy_o(busy), .serial_enable_o(sen));
  ssw_host_model #(.KICK_PER(100)) host (.mclk_i(mclk_i), .kick_en_i(kick_en), .pull_low_i(pull),
    .oe_i(oe_n), .kick_o(kick), .pin_o(pin));
  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // One-bit comparison
  task chk(input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: exp %0h got %0h", $time, e, g);
    end
  endtask
  // Sample on falling edges, after updates settle
  task cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Bounded wait for the reset enable level
  task wait_oe(input logic v, input int n);
    for (int i = 0; i < n && oe_n !== v; i++) @(negedge mclk_i);
    chk(v, oe_n);
  endtask
  // Power-up: low supply holds reset, then timeout
  task t_supply;
    cyc(3);
    chk(1'b1, oe_n);
    chk(1'b1, oe_p);
    chk(1'b0, n_o);
    chk(1'b1, p_o);
    chk(1'b0, allow);
    @(posedge mclk_i) sup <= 1'b0;
    cyc(45);
    chk(1'b1, oe_n);
    wait_oe(1'b0, 20);
    chk(1'b0, oe_p);
    chk(1'b1, allow);
  endtask
  // Protect pin, then a write and its busy window
  task t_write;
    @(posedge mclk_i) wp_conn <= 1'b1;
    wp <= 1'b1;
    cyc(2);
    chk(1'b0, allow);
    @(posedge mclk_i) wp_conn <= 1'b0;
    req <= 1'b0;
    cyc(2);
    chk(1'b0, allow);
    @(posedge mclk_i) req <= 1'b1;
    addr <= 8'h10;
    cyc(2);
    chk(1'b1, allow);
    @(posedge mclk_i) stop <= 1'b1;
    @(posedge mclk_i) stop <= 1'b0;
    cyc(1);
    chk(1'b1, busy);
    chk(1'b0, sen);
    chk(1'b0, allow);
    cyc(10);
    chk(1'b1, busy);
    cyc(15);
    chk(1'b0, busy);
    chk(1'b1, sen);
  endtask
  // Kicks keep reset off; silence makes it fire
  task t_wdog;
    cyc(600);
    chk(1'b0, oe_n);
    @(posedge mclk_i) kick_en <= 1'b0;
    // Serial line activity must not feed the kick-pin build
    repeat (15) begin
      cyc(5);
      @(posedge mclk_i) sda <= ~sda;
    end
    cyc(20);
    chk(1'b0, oe_n);
    wait_oe(1'b1, 150);
    @(posedge mclk_i) kick_en <= 1'b1;
    wait_oe(1'b0, 120);
    cyc(150);
    chk(1'b0, oe_n);
  endtask
  // Manual input held low, then left open
  task t_manual;
    @(posedge mclk_i) man <= 1'b0;
    cyc(10);
    @(posedge mclk_i) man <= 1'b1;
    cyc(20);
    chk(1'b0, oe_n);
    @(posedge mclk_i) man <= 1'b0;
    cyc(1100);
    chk(1'b1, oe_n);
    cyc(300);
    chk(1'b1, oe_n);
    @(posedge mclk_i) man <= 1'b1;
    cyc(30);
    chk(1'b1, oe_n);
    cyc(1010);
    chk(1'b1, oe_n);
    wait_oe(1'b0, 200);
    @(posedge mclk_i) man_conn <= 1'b0;
    man <= 1'b0;
    cyc(1200);
    chk(1'b0, oe_n);
    @(posedge mclk_i) man <= 1'b1;
    man_conn <= 1'b1;
  endtask
  // Host sinks the reset wire briefly
  task t_pin;
    @(posedge mclk_i) pull <= 1'b1;
    cyc(4);
    chk(1'b1, oe_n);
    @(posedge mclk_i) pull <= 1'b0;
    cyc(30);
    chk(1'b1, oe_n);
    wait_oe(1'b0, 40);
  endtask
  // Verdict and end of run
  task final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well beyond the expected 4800 cycles
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_supply();
    t_write();
    t_wdog();
    t_manual();
    t_pin();
    final_report();
  end
endmodule
